// [hw/cts_condition_table_selector.sv]
// Operation
// - three tables, three conditions each; argument one picked by block type and instance
// - argument two is another block output or a stored unitless constant
// - operator codes: 0 eq, 1 ne, 2 gt, 3 ge, 4 lt, 5 le
// - operator resets to equal; changed only when both argument sources are valid
// - both sources reset to not used; an unused argument gives not applicable
// - result 0 false, 1 true when both arguments are valid
// - result 2 when both arguments are available and either source reports an error
// - result 3 when either argument is unavailable
// - combining codes: 0 default, 1 and3, 2 or3, 3 and-or, 4 or-and
// - a default table is selected as soon as it is reached
// - all-and: false or error rejects; not applicable counts as true
// - all-or: any true selects; error and not applicable count false
// - code 3: (first and second) or third, only true counts
// - code 4: (first or second) and third, only true counts
// - tables evaluated in ascending order; first selected table wins
// - selected table's value passes to the logic output unchanged
// - block inactive until enabled; disabled after reset
`default_nettype none

module cts_condition_table_selector
(
  input  wire logic                                  pclk,
  input  wire logic                                  presetn,
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [cts_pkg::ADDR_W-1:0]            paddr,
  input  wire logic [31:0]                           pwdata,
  output logic      [31:0]                           prdata,
  output logic                                       pready,
  output logic                                       pslverr,
  input  wire logic [cts_pkg::NUM_SRC*cts_pkg::DATA_W-1:0] src_value,
  input  wire logic [cts_pkg::NUM_SRC-1:0]           src_error,
  input  wire logic [cts_pkg::NUM_SRC-1:0]           src_avail,
  input  wire logic [cts_pkg::NUM_TBL*cts_pkg::DATA_W-1:0] tbl_value,
  input  wire logic [cts_pkg::NUM_TBL-1:0]           tbl_avail,
  output logic      [1:0]                            sel_table,
  output logic      [cts_pkg::DATA_W-1:0]            logic_out,
  output logic                                       logic_out_valid
);
  import cts_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // argument one source: a block type with an instance number
  function automatic logic src_ok(input logic [3:0] s, input logic [3:0] n);
    src_ok = (s >= SRC_FIRST) && (s <= SRC_LAST) && (n >= INST_FIRST) && (n <= INST_LAST);
  endfunction

  // argument two may also be the constant
  function automatic logic arg2_ok(input logic [3:0] s, input logic [3:0] n);
    arg2_ok = (s == SRC_CONST) || src_ok(s, n);
  endfunction

  // flat index of a source: type and instance, both counted from one
  function automatic logic [3:0] src_idx(input logic [3:0] s, input logic [3:0] n);
    logic [3:0] sm;
    logic [3:0] nm;
    sm      = s - SRC_FIRST;
    nm      = n - INST_FIRST;
    src_idx = {sm[1:0], nm[1:0]};
  endfunction

  // ----------------------------------------------------------------
  // configuration storage
  // ----------------------------------------------------------------

  logic              enable;
  logic [8:0]        tbl_op;
  logic [3:0]        a1_src   [NUM_ALL];
  logic [3:0]        a1_num   [NUM_ALL];
  logic [3:0]        a2_src   [NUM_ALL];
  logic [3:0]        a2_num   [NUM_ALL];
  logic [2:0]        cmp_op   [NUM_ALL];
  logic [DATA_W-1:0] cnst     [NUM_ALL];

  logic              next_enable;
  logic [8:0]        next_tbl_op;
  logic [3:0]        next_a1_src [NUM_ALL];
  logic [3:0]        next_a1_num [NUM_ALL];
  logic [3:0]        next_a2_src [NUM_ALL];
  logic [3:0]        next_a2_num [NUM_ALL];
  logic [2:0]        next_cmp_op [NUM_ALL];
  logic [DATA_W-1:0] next_cnst   [NUM_ALL];

  // bus decode
  logic              wr_done;
  logic              in_cnd;
  logic [ADDR_W-1:0] cnd_off;
  logic [3:0]        cnd_sel;
  logic              cnd_const;
  logic              addr_ok;

  // evaluation state
  logic [1:0]        res      [NUM_ALL];
  logic [1:0]        res_q    [NUM_ALL];
  logic [1:0]        next_res [NUM_ALL];
  logic [NUM_TBL-1:0] tbl_hit;
  logic [1:0]        next_sel_table;
  logic [DATA_W-1:0] next_logic_out;
  logic              next_logic_out_valid;

  logic [31:0]       next_prdata;
  logic              next_pready;
  logic              next_pslverr;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------

  // a write lands only on the completing access edge
  always_comb
  begin
    wr_done   = psel && penable && pready && pwrite;
    in_cnd    = (paddr >= ADDR_CND_LO) && (paddr < ADDR_CND_HI) && (paddr[1:0] == 2'h0);
    cnd_off   = paddr - ADDR_CND_LO;
    cnd_sel   = cnd_off[CND_STRIDE_SH +: 4];
    cnd_const = cnd_off[2];
    addr_ok   = in_cnd || (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS)
                || (paddr == ADDR_TBL_OP) || (paddr == ADDR_RESULTS);
  end

  // ----------------------------------------------------------------
  // register file next values
  // ----------------------------------------------------------------

  always_comb
  begin
    next_enable = enable;
    next_tbl_op = tbl_op;
    for (int i = 0; i < NUM_ALL; i++)
    begin
      next_a1_src[i] = a1_src[i];
      next_a1_num[i] = a1_num[i];
      next_a2_src[i] = a2_src[i];
      next_a2_num[i] = a2_num[i];
      next_cmp_op[i] = cmp_op[i];
      next_cnst[i]   = cnst[i];
    end
    if (wr_done && (paddr == ADDR_CTRL))
      next_enable = pwdata[0];
    if (wr_done && (paddr == ADDR_TBL_OP))
      next_tbl_op = pwdata[8:0];
    for (int i = 0; i < NUM_ALL; i++)
    begin
      if (wr_done && in_cnd && (cnd_sel == 4'(i)) && cnd_const)
        next_cnst[i] = pwdata[DATA_W-1:0];
      if (wr_done && in_cnd && (cnd_sel == 4'(i)) && !cnd_const)
      begin
        next_a1_src[i] = pwdata[CFG_A1_SRC_LSB +: 4];
        next_a1_num[i] = pwdata[CFG_A1_NUM_LSB +: 4];
        next_a2_src[i] = pwdata[CFG_A2_SRC_LSB +: 4];
        next_a2_num[i] = pwdata[CFG_A2_NUM_LSB +: 4];
        // operator taken only with two valid sources in the same word
        if (src_ok(pwdata[CFG_A1_SRC_LSB +: 4], pwdata[CFG_A1_NUM_LSB +: 4])
            && arg2_ok(pwdata[CFG_A2_SRC_LSB +: 4], pwdata[CFG_A2_NUM_LSB +: 4]))
          next_cmp_op[i] = pwdata[CFG_OP_LSB +: 3];
      end
    end
  end

  // register file storage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable <= RST_ENABLE;
      tbl_op <= RST_TBL_OP;
      for (int i = 0; i < NUM_ALL; i++)
      begin
        a1_src[i] <= RST_SRC;
        a1_num[i] <= RST_NUM;
        a2_src[i] <= RST_SRC;
        a2_num[i] <= RST_NUM;
        cmp_op[i] <= RST_OP;
        cnst[i]   <= RST_CONST;
      end
    end
    else
    begin
      enable <= next_enable;
      tbl_op <= next_tbl_op;
      for (int i = 0; i < NUM_ALL; i++)
      begin
        a1_src[i] <= next_a1_src[i];
        a1_num[i] <= next_a1_num[i];
        a2_src[i] <= next_a2_src[i];
        a2_num[i] <= next_a2_num[i];
        cmp_op[i] <= next_cmp_op[i];
        cnst[i]   <= next_cnst[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // condition evaluation
  // ----------------------------------------------------------------

  for (genvar g = 0; g < NUM_ALL; g++)
  begin : g_cnd
    logic [DATA_W-1:0] a_v, b_v;
    logic              a_e, b_e, a_a, b_a;
    logic [3:0]        ai, bi;

    // argument selection from the neighbouring block outputs
    always_comb
    begin
      ai  = src_idx(a1_src[g], a1_num[g]);
      bi  = src_idx(a2_src[g], a2_num[g]);
      a_a = src_ok(a1_src[g], a1_num[g]) && src_avail[ai];
      a_e = src_error[ai];
      a_v = src_value[32'(ai) * DATA_W +: DATA_W];
      if (a2_src[g] == SRC_CONST)
      begin
        b_a = 1'b1;
        b_e = 1'b0;
        b_v = cnst[g];
      end
      else
      begin
        b_a = src_ok(a2_src[g], a2_num[g]) && src_avail[bi];
        b_e = src_error[bi];
        b_v = src_value[32'(bi) * DATA_W +: DATA_W];
      end
    end

    cts_cond_eval u_eval (
      .a_value (a_v),
      .a_error (a_e),
      .a_avail (a_a),
      .b_value (b_v),
      .b_error (b_e),
      .b_avail (b_a),
      .op      (cmp_op[g]),
      .result  (res[g])
    );
  end

  // per-table combining
  for (genvar t = 0; t < NUM_TBL; t++)
  begin : g_tbl
    cts_tbl_combine u_comb (
      .res1   (res[t*NUM_CND]),
      .res2   (res[t*NUM_CND+1]),
      .res3   (res[t*NUM_CND+2]),
      .op     (tbl_op[t*TBL_OP_W +: TBL_OP_W]),
      .select (tbl_hit[t])
    );
  end

  // ----------------------------------------------------------------
  // table selection and output
  // ----------------------------------------------------------------

  // lowest selected table wins, recomputed every cycle
  always_comb
  begin
    next_sel_table       = SEL_NONE;
    next_logic_out       = '0;
    next_logic_out_valid = 1'b0;
    for (int i = 0; i < NUM_ALL; i++)
      next_res[i] = enable ? res[i] : RES_NA;
    if (enable)
    begin
      for (int t = NUM_TBL - 1; t >= 0; t--)
      begin
        if (tbl_hit[t])
        begin
          next_sel_table       = 2'(t + 1);
          next_logic_out       = tbl_value[t*DATA_W +: DATA_W];
          next_logic_out_valid = tbl_avail[t];
        end
      end
    end
  end

  // registered evaluation result
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_table       <= SEL_NONE;
      logic_out       <= '0;
      logic_out_valid <= 1'b0;
      for (int i = 0; i < NUM_ALL; i++)
        res_q[i] <= RES_NA;
    end
    else
    begin
      sel_table       <= next_sel_table;
      logic_out       <= next_logic_out;
      logic_out_valid <= next_logic_out_valid;
      for (int i = 0; i < NUM_ALL; i++)
        res_q[i] <= next_res[i];
    end
  end

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------

  // answer prepared in the setup cycle, presented in the access cycle
  always_comb
  begin
    next_pready  = psel && !penable;
    next_pslverr = psel && !penable && !addr_ok;
    next_prdata  = prdata;
    if (psel && !penable)
    begin
      next_prdata = '0;
      if (paddr == ADDR_CTRL)
        next_prdata[0] = enable;
      else if (paddr == ADDR_STATUS)
        next_prdata[STAT_VALID_BIT:0] = {logic_out_valid, sel_table};
      else if (paddr == ADDR_TBL_OP)
        next_prdata[8:0] = tbl_op;
      else if (paddr == ADDR_RESULTS)
      begin
        for (int i = 0; i < NUM_ALL; i++)
          next_prdata[2*i +: 2] = res_q[i];
      end
      else if (in_cnd && cnd_const)
      begin
        for (int i = 0; i < NUM_ALL; i++)
          if (cnd_sel == 4'(i))
            next_prdata[DATA_W-1:0] = cnst[i];
      end
      else if (in_cnd)
      begin
        for (int i = 0; i < NUM_ALL; i++)
          if (cnd_sel == 4'(i))
            next_prdata[18:0] = {cmp_op[i], a2_num[i], a2_src[i], a1_num[i], a1_src[i]};
      end
    end
  end

  // bus answer flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

endmodule

`default_nettype wire

// [hw/cts_pkg.sv]
`default_nettype none

package cts_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int DATA_W  = 16;   // width of a logical output value
  localparam int NUM_TBL = 3;    // candidate tables
  localparam int NUM_CND = 3;    // conditions per table
  localparam int NUM_ALL = 9;    // conditions in total
  localparam int NUM_SRC = 16;   // block types times instances
  localparam int ADDR_W  = 12;

  // ----------------------------------------------------------------
  // argument source codes
  // ----------------------------------------------------------------
  localparam logic [3:0] SRC_NONE   = 4'h0;  // control source not used
  localparam logic [3:0] SRC_FIRST  = 4'h1;  // first block type
  localparam logic [3:0] SRC_LAST   = 4'h4;  // last block type
  localparam logic [3:0] SRC_CONST  = 4'hf;  // user constant, second argument only
  localparam logic [3:0] INST_FIRST = 4'h1;
  localparam logic [3:0] INST_LAST  = 4'h4;

  // ----------------------------------------------------------------
  // comparison operators
  // ----------------------------------------------------------------
  localparam logic [2:0] CMP_EQ = 3'h0;
  localparam logic [2:0] CMP_NE = 3'h1;
  localparam logic [2:0] CMP_GT = 3'h2;
  localparam logic [2:0] CMP_GE = 3'h3;
  localparam logic [2:0] CMP_LT = 3'h4;
  localparam logic [2:0] CMP_LE = 3'h5;

  // ----------------------------------------------------------------
  // condition results
  // ----------------------------------------------------------------
  localparam logic [1:0] RES_FALSE = 2'h0;
  localparam logic [1:0] RES_TRUE  = 2'h1;
  localparam logic [1:0] RES_ERROR = 2'h2;
  localparam logic [1:0] RES_NA    = 2'h3;

  // ----------------------------------------------------------------
  // combining operators
  // ----------------------------------------------------------------
  localparam logic [2:0] CMB_DEFAULT = 3'h0;
  localparam logic [2:0] CMB_AND3    = 3'h1;
  localparam logic [2:0] CMB_OR3     = 3'h2;
  localparam logic [2:0] CMB_AND_OR  = 3'h3;
  localparam logic [2:0] CMB_OR_AND  = 3'h4;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL    = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_TBL_OP  = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_RESULTS = 12'h00c;
  localparam logic [ADDR_W-1:0] ADDR_CND_LO  = 12'h020;  // cfg at +0, constant at +4
  localparam logic [ADDR_W-1:0] ADDR_CND_HI  = 12'h068;  // first address past the block
  localparam int                CND_STRIDE_SH = 3;       // eight bytes per condition

  // condition configuration word fields
  localparam int CFG_A1_SRC_LSB = 0;
  localparam int CFG_A1_NUM_LSB = 4;
  localparam int CFG_A2_SRC_LSB = 8;
  localparam int CFG_A2_NUM_LSB = 12;
  localparam int CFG_OP_LSB     = 16;
  localparam int TBL_OP_W       = 3;   // one combining field per table, table 1 lowest
  localparam int STAT_VALID_BIT = 2;   // status: [1:0] selected table, [2] output valid

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic       RST_ENABLE = 1'b0;
  localparam logic [8:0] RST_TBL_OP = 9'h009;   // tables 1,2 all-and, table 3 default
  localparam logic [3:0] RST_SRC    = SRC_NONE;
  localparam logic [3:0] RST_NUM    = 4'h0;
  localparam logic [2:0] RST_OP     = CMP_EQ;
  localparam logic [DATA_W-1:0] RST_CONST = 16'h0000;
  localparam logic [1:0] SEL_NONE   = 2'h0;     // no table selected

endpackage

`default_nettype wire

// [hw/cts_cond_eval.sv]
`default_nettype none

module cts_cond_eval
  import cts_pkg::*;
(
  input  wire logic [cts_pkg::DATA_W-1:0] a_value,
  input  wire logic                        a_error,
  input  wire logic                        a_avail,
  input  wire logic [cts_pkg::DATA_W-1:0] b_value,
  input  wire logic                        b_error,
  input  wire logic                        b_avail,
  input  wire logic [2:0]                  op,
  output logic      [1:0]                  result
);

  // ----------------------------------------------------------------
  // four-valued condition result
  // ----------------------------------------------------------------

  // unavailable beats error, error beats comparison
  always_comb
  begin
    if (!a_avail || !b_avail)
      result = RES_NA;
    else if (a_error || b_error)
      result = RES_ERROR;
    else
    begin
      case (op)
        CMP_EQ:  result = (a_value == b_value) ? RES_TRUE : RES_FALSE;
        CMP_NE:  result = (a_value != b_value) ? RES_TRUE : RES_FALSE;
        CMP_GT:  result = (a_value >  b_value) ? RES_TRUE : RES_FALSE;
        CMP_GE:  result = (a_value >= b_value) ? RES_TRUE : RES_FALSE;
        CMP_LT:  result = (a_value <  b_value) ? RES_TRUE : RES_FALSE;
        CMP_LE:  result = (a_value <= b_value) ? RES_TRUE : RES_FALSE;
        default: result = RES_FALSE;                    // unused codes never hold
      endcase
    end
  end

endmodule

`default_nettype wire

// [hw/cts_tbl_combine.sv]
`default_nettype none

module cts_tbl_combine
  import cts_pkg::*;
(
  input  wire logic [1:0] res1,
  input  wire logic [1:0] res2,
  input  wire logic [1:0] res3,
  input  wire logic [2:0] op,
  output logic            select
);

  // ----------------------------------------------------------------
  // table selection from three condition results
  // ----------------------------------------------------------------

  logic t1, t2, t3;   // strictly true
  logic n1, n2, n3;   // true or not applicable

  // truth views of each result
  always_comb
  begin
    t1 = (res1 == RES_TRUE);
    t2 = (res2 == RES_TRUE);
    t3 = (res3 == RES_TRUE);
    n1 = t1 || (res1 == RES_NA);
    n2 = t2 || (res2 == RES_NA);
    n3 = t3 || (res3 == RES_NA);
  end

  // combining operator
  always_comb
  begin
    case (op)
      CMB_DEFAULT: select = 1'b1;
      CMB_AND3:    select = n1 && n2 && n3;
      CMB_OR3:     select = t1 || t2 || t3;
      CMB_AND_OR:  select = (t1 && t2) || t3;
      CMB_OR_AND:  select = (t1 || t2) && t3;
      default:     select = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

// [dv/cts_checker_properties.sv]
`default_nettype none

module cts_checker
  import cts_pkg::*;
(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic [255:0] src_value,
  input wire logic [15:0]  src_error,
  input wire logic [15:0]  src_avail,
  input wire logic [47:0]  tbl_value,
  input wire logic [2:0]   tbl_avail,
  input wire logic [1:0]   sel_table,
  input wire logic [15:0]  logic_out,
  input wire logic         logic_out_valid
);
  // ------------------------------------------------
  // bus answer and selection output properties
  // ------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence quiet_s;
    (!psel && $stable(src_value) && $stable(src_error) && $stable(src_avail)
      && $stable(tbl_value) && $stable(tbl_avail)) [*2];
  endsequence
  AST_SETUP_ANSWER: assert property (setup_s |=> pready)
    else $error("no answer after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_NONE_INVALID: assert property (
    sel_table == 2'h0 |-> !logic_out_valid && logic_out == 16'h0)
    else $error("output valid with no table");
  AST_PASS_VALUE: assert property (
    logic_out_valid |-> logic_out == 16'($past(tbl_value) >> (16 * (sel_table - 2'h1))))
    else $error("output differs from table value");
  AST_VALID_AVAIL: assert property (
    logic_out_valid |-> (($past(tbl_avail) >> (sel_table - 2'h1)) & 3'h1) != 3'h0)
    else $error("valid with table value missing");
  AST_RESET_DISABLED: assert property ($rose(presetn) |-> (sel_table == 2'h0) [*2])
    else $error("table selected after reset");
  AST_STEADY: assert property (quiet_s |=> $stable(sel_table) && $stable(logic_out))
    else $error("selection moved with steady inputs");
  COV_SELECTED: cover property (logic_out_valid && sel_table == 2'h3);
endmodule

bind cts_condition_table_selector cts_checker cts_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .src_value(src_value), .src_error(src_error), .src_avail(src_avail),
  .tbl_value(tbl_value), .tbl_avail(tbl_avail), .sel_table(sel_table),
  .logic_out(logic_out), .logic_out_valid(logic_out_valid));

`default_nettype wire

// [dv/cts_src_model.sv]
`default_nettype none

module cts_src_model
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [3:0]   set_idx,
  input  wire logic [15:0]  set_val,
  input  wire logic         set_err,
  input  wire logic         set_avail,
  input  wire logic [2:0]   tavail,
  output var  logic [255:0] src_value,
  output var  logic [15:0]  src_error,
  output var  logic [15:0]  src_avail,
  output logic      [47:0]  tbl_value,
  output logic      [2:0]   tbl_avail
);
  // ------------------------------------------------
  // neighbour blocks; a missing source shows a scrambled value
  // ------------------------------------------------
  assign tbl_value = {16'h3333, 16'h2222, 16'h1111};
  assign tbl_avail = tavail;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src_value <= '1;
      src_error <= '0;
      src_avail <= '0;
    end
    else
    begin
      src_value[set_idx*16+:16] <= set_avail ? set_val : ~set_val;
      src_error[set_idx]        <= set_err;
      src_avail[set_idx]        <= set_avail;
    end
  end
endmodule

`default_nettype wire

// [dv/testbench.sv]
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end

module testbench
  import cts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, logic_out_valid;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata;
  logic [255:0] src_value;
  logic [15:0]  src_error, src_avail, logic_out, set_val;
  logic [47:0]  tbl_value;
  logic [2:0]   tbl_avail, tavail;
  logic [1:0]   sel_table;
  logic [3:0]   set_idx;
  logic         set_err, set_avail;
  int           fails, num_checks;

  cts_condition_table_selector cts_condition_table_selector_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_value(src_value), .src_error(src_error), .src_avail(src_avail),
    .tbl_value(tbl_value), .tbl_avail(tbl_avail), .sel_table(sel_table),
    .logic_out(logic_out), .logic_out_valid(logic_out_valid));
  cts_src_model cts_src_model_inst (.pclk(pclk), .presetn(presetn), .set_idx(set_idx),
    .set_val(set_val), .set_err(set_err), .set_avail(set_avail), .tavail(tavail),
    .src_value(src_value), .src_error(src_error), .src_avail(src_avail),
    .tbl_value(tbl_value), .tbl_avail(tbl_avail));

  // ------------------------------------------------
  // bus cycles and helpers
  // ------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hung transfer
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK("prdata", x, r)
    `CHK("pslverr", xe, e)
  endtask
  // result code r: 0 false, 1 true, 2 error, 3 unavailable
  task automatic setsrc(input int k, input int r);
    set_idx   <= 4'(k);
    set_val   <= (r == 0) ? 16'h6 : 16'h5;
    set_err   <= (r == 2);
    set_avail <= (r != 3);
    @(posedge pclk);
  endtask
  function automatic logic [31:0] cfg(input int i, input int op);
    return 32'h0f01 | 32'((i + 1) << 4) | 32'(op << 16);
  endfunction
  function automatic logic [1:0] cmp(input int op, input int b);
    case (op)
      0: return (5 == b) ? 2'h1 : 2'h0;
      1: return (5 != b) ? 2'h1 : 2'h0;
      2: return (5 > b) ? 2'h1 : 2'h0;
      3: return (5 >= b) ? 2'h1 : 2'h0;
      4: return (5 < b) ? 2'h1 : 2'h0;
      default: return (5 <= b) ? 2'h1 : 2'h0;
    endcase
  endfunction
  function automatic logic [1:0] exp_sel(input int c, input int p);
    bit t1, t2, t3, s;
    t1 = (p & 3) == 1;
    t2 = ((p >> 2) & 3) == 1;
    t3 = ((p >> 4) & 3) == 1;
    case (c)
      0: s = 1;
      1: s = (t1 || (p & 3) == 3) && (t2 || ((p >> 2) & 3) == 3)
             && (t3 || ((p >> 4) & 3) == 3);
      2: s = t1 || t2 || t3;
      3: s = (t1 && t2) || t3;
      default: s = (t1 || t2) && t3;
    endcase
    return s ? 2'h1 : 2'h3;
  endfunction
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    fails++;
    print_verdict();
  end
  // ------------------------------------------------
  // test sequence
  // ------------------------------------------------
  initial
  begin
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h0;
    pwdata     = 32'h0;
    set_idx    = 4'h0;
    set_val    = 16'h0;
    set_err    = 1'b0;
    set_avail  = 1'b0;
    tavail     = 3'h7;
    fails      = 0;
    num_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_CTRL, 32'h0, 1'b0);
    rd(ADDR_TBL_OP, 32'h9, 1'b0);
    rd(ADDR_RESULTS, 32'h3ffff, 1'b0);
    rd(12'h100, 32'h0, 1'b1);
    wr(ADDR_CND_LO, 32'h20000);
    rd(ADDR_CND_LO, 32'h0, 1'b0);
    wr(ADDR_CTRL, 32'h1);
    setsrc(0, 1);
    for (int b = 4; b <= 6; b++)
      for (int o = 0; o <= 5; o++)
      begin
        wr(ADDR_CND_LO, cfg(0, o));
        wr(ADDR_CND_LO + 12'h4, 32'(b));
        rd(ADDR_RESULTS, 32'h3fffc | 32'(cmp(o, b)), 1'b0);
      end
    for (int i = 0; i < 3; i++)
    begin
      wr(ADDR_CND_LO + 12'(8 * i), cfg(i, 0));
      wr(ADDR_CND_LO + 12'(8 * i + 4), 32'h5);
    end
    rd(ADDR_CND_LO + 12'h8, cfg(1, 0), 1'b0);
    for (int c = 0; c <= 4; c++)
    begin
      wr(ADDR_TBL_OP, 32'(c) | 32'h10);
      for (int p = 0; p < 64; p++)
      begin
        for (int i = 0; i < 3; i++) setsrc(i, (p >> (2 * i)) & 3);
        repeat (3) @(posedge pclk);
        `CHK("sel_table", exp_sel(c, p), sel_table)
        `CHK("logic_out", 16'h1111 * exp_sel(c, p), logic_out)
        `CHK("logic_out_valid", 1'b1, logic_out_valid)
        rd(ADDR_RESULTS, 32'h3ffc0 | 32'(p), 1'b0);
      end
    end
    tavail <= 3'h6;
    wr(ADDR_TBL_OP, 32'h10);
    rd(ADDR_STATUS, 32'h1, 1'b0);
    wr(ADDR_CTRL, 32'h0);
    rd(ADDR_STATUS, 32'h0, 1'b0);
    rd(ADDR_RESULTS, 32'h3ffff, 1'b0);
    print_verdict();
  end
endmodule

`default_nettype wire
